// ---- bench/test_watchdog_and_supply_monitor.sv ----
// Self-checking bench for the watchdog control end and the supply monitor
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_and_supply_monitor;
  localparam int WD = 50;
  localparam int RC = 40;
  // Two sync flops plus four filter cycles
  localparam int FL = 6;
  logic i_core_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [7:0] i_sfr_addr = 8'h00;
  logic i_sfr_wr = 1'b0;
  logic i_sfr_rd = 1'b0;
  logic [7:0] i_sfr_wdata = 8'h00;
  logic i_instr_end = 1'b0;
  logic i_supply_irq_en = 1'b0;
  logic i_analog_supply_comparator = 1'b1;
  logic i_digital_supply_comparator = 1'b1;
  logic [7:0] o_sfr_rdata;
  logic o_supply_monitor_on;
  logic [1:0] o_trip_sel_a;
  logic [1:0] o_trip_sel_d;
  logic o_supply_irq;
  logic o_wdog_enable_bit;
  logic o_wdog_irq;
  logic o_wdog_rst;
  logic [7:0] rv;
  int mismatches = 0;
  int comparisons = 0;

  // Short counts keep the run brief
  wsm_top #(.WDOG_CYCLES(32'h0000_0032), .RECOVER_CYCLES(32'h0000_0028), .FILT_CYCLES(16'h0004)) dut (
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
    .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata), .i_instr_end(i_instr_end),
    .i_supply_irq_en(i_supply_irq_en), .i_analog_supply_comparator(i_analog_supply_comparator),
    .i_digital_supply_comparator(i_digital_supply_comparator), .o_supply_monitor_on(o_supply_monitor_on),
    .o_trip_sel_a(o_trip_sel_a), .o_trip_sel_d(o_trip_sel_d), .o_supply_irq(o_supply_irq),
    .o_wdog_enable_bit(o_wdog_enable_bit), .o_wdog_irq(o_wdog_irq), .o_wdog_rst(o_wdog_rst));

  // 10 MHz core clock
  always #50 i_core_clk = ~i_core_clk;

  // Verdict and end of run
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  // One register write, optionally ending the instruction in the same cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ie);
    @(posedge i_core_clk);
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    i_sfr_wr <= 1'b1;
    i_instr_end <= ie;
    @(posedge i_core_clk);
    i_sfr_wr <= 1'b0;
    i_instr_end <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    i_sfr_addr <= a;
    i_sfr_rd <= 1'b1;
    @(posedge i_core_clk);
    i_sfr_rd <= 1'b0;
    #1 d = o_sfr_rdata;
  endtask

  // Unlocked write of the watchdog control register
  task automatic unl(input logic [7:0] d);
    wr(8'hC0, 8'h01, 1'b1);
    wr(8'hC0, d, 1'b0);
  endtask

  task automatic pulse_end();
    @(posedge i_core_clk);
    i_instr_end <= 1'b1;
    @(posedge i_core_clk);
    i_instr_end <= 1'b0;
  endtask

  // Counts cycles to a timeout pulse and checks the exact window
  task automatic wait_to(input int lo, input int hi, input logic irq);
    int n;
    for (n = 1; n <= hi + 5; n++) begin
      @(posedge i_core_clk);
      #1;
      if ((irq ? o_wdog_irq : o_wdog_rst) === 1'b1) break;
    end
    if (n > hi + 5) begin
      mismatches++;
      $display("[FAIL] %0t timeout pulse missing", $time);
      wrap_up();
    end
    chk({7'h00, (n >= lo && n <= hi)}, 8'h01);
  endtask

  task automatic wait_irq(input logic want, input int lim);
    int n;
    for (n = 0; n < lim && o_supply_irq !== want; n++) cyc(1);
    #1;
    if (o_supply_irq !== want) begin
      mismatches++;
      $display("[FAIL] %0t supply interrupt level not reached", $time);
      wrap_up();
    end
  endtask

  task automatic t_reset();
    rd(8'hDF, rv);
    chk(rv, 8'hDE); // reset value
    rd(8'hC0, rv);
    chk(rv, 8'h00); // hardware reset clears enable
    rd(8'h55, rv);
    chk(rv, 8'h00); // unmapped read
    chk({6'h00, o_trip_sel_d}, 8'h03); // trip default
    chk({7'h00, o_supply_monitor_on}, 8'h00); // monitor off
  endtask

  task automatic t_lock();
    wr(8'hC0, 8'h02, 1'b0);
    #1 chk({7'h00, o_wdog_enable_bit}, 8'h00); // write without unlock
    wr(8'hC0, 8'h01, 1'b1);
    pulse_end();
    wr(8'hC0, 8'h02, 1'b0);
    #1 chk({7'h00, o_wdog_enable_bit}, 8'h00); // unlock expired
    wr(8'hC0, 8'h01, 1'b1);
    rd(8'hC0, rv);
    chk(rv, 8'h01); // unlock open
    wr(8'hC0, 8'h02, 1'b0);
    #1 chk({7'h00, o_wdog_enable_bit}, 8'h01); // enabled
  endtask

  task automatic t_wdog();
    unl(8'h02);
    wait_to(WD, WD, 1'b0); // reset response
    #1 chk({7'h00, o_wdog_enable_bit}, 8'h00); // cleared by reset response
    rd(8'hC0, rv);
    chk(rv, 8'h04); // status set by timeout
    unl(8'h0A);
    cyc(30);
    unl(8'h0A);
    wait_to(WD, WD, 1'b1); // rewrite restarts count
    chk({7'h00, o_wdog_enable_bit}, 8'h01); // interrupt keeps enable
    wait_to(WD - 1, WD + 1, 1'b1); // interrupt again
    unl(8'h00);
    #1 chk({7'h00, o_wdog_enable_bit}, 8'h00); // written zero
  endtask

  task automatic t_supply();
    wr(8'hDF, 8'h01, 1'b0);
    #1 chk({5'h00, o_supply_monitor_on, o_trip_sel_a}, 8'h04); // monitor on, trip 00
    chk({6'h00, o_trip_sel_d}, 8'h00); // digital trip written
    unl(8'h02);
    i_supply_irq_en <= 1'b1;
    i_analog_supply_comparator <= 1'b0;
    cyc(2);
    i_analog_supply_comparator <= 1'b1;
    cyc(20);
    chk({7'h00, o_supply_irq}, 8'h00); // glitch filtered
    i_analog_supply_comparator <= 1'b0;
    wait_irq(1'b1, 20); // low sets flag
    cyc(1);
    chk({7'h00, o_wdog_enable_bit}, 8'h00); // supply interrupt clears enable
    wr(8'hDF, 8'h01, 1'b0);
    rd(8'hDF, rv);
    chk(rv, 8'hA1); // clear ignored while low
    cyc(1);
    i_analog_supply_comparator <= 1'b1;
    cyc(RC + FL);
    chk({7'h00, o_supply_irq}, 8'h01); // held through the whole recovery
    cyc(1);
    chk({7'h00, o_supply_irq}, 8'h00); // clears right after recovery
    i_supply_irq_en <= 1'b0;
    unl(8'h02);
    i_digital_supply_comparator <= 1'b0;
    cyc(20);
    chk({7'h00, o_supply_irq}, 8'h00); // masked
    chk({7'h00, o_wdog_enable_bit}, 8'h01); // masked alarm leaves watchdog on
    unl(8'h00);
    rd(8'hDF, rv);
    chk(rv, 8'h61); // digital supply watched
    cyc(1);
    i_digital_supply_comparator <= 1'b1;
    cyc(12);
    wr(8'hDF, 8'h01, 1'b0);
    rd(8'hDF, rv);
    chk(rv, 8'hC1); // clear taken when good
    wr(8'hDF, 8'h00, 1'b0);
    i_analog_supply_comparator <= 1'b0;
    cyc(12);
    rd(8'hDF, rv);
    chk(rv, 8'h80); // monitor off raises no alarm
  endtask

  // Main sequence
  initial begin
    cyc(20);
    i_arst_n <= 1'b1;
    t_reset();
    t_lock();
    t_wdog();
    t_supply();
    wrap_up();
  end
endmodule
`default_nettype wire

// ---- verilog/wsm_filt.sv ----
// Two-flop synchroniser and glitch filter for one supply comparator
`timescale 1ns/1ps
`default_nettype none
module wsm_filt #(
  parameter logic [wsm_pkg::FILT_W-1:0] STABLE_CYCLES = 16'(wsm_pkg::FILTER_US * (wsm_pkg::CLK_HZ / 1_000_000))
) (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_cmp_async,
  output logic o_level
);
  wsm_pkg::wsm_filt_t s;
  wsm_pkg::wsm_filt_t next_s;

  // Level follows the synchronised input only after it stays put
  always_comb begin
    next_s = s;
    next_s.s1 = i_cmp_async;
    next_s.s2 = s.s1;
    if (s.s2 == s.level) begin
      next_s.cnt = '0;
    end else if (s.cnt == STABLE_CYCLES - wsm_pkg::FILT_ONE) begin
      next_s.level = s.s2;
      next_s.cnt = '0;
    end else begin
      next_s.cnt = s.cnt + wsm_pkg::FILT_ONE;
    end
  end

  // State register, supply assumed good at reset
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s <= '{s1: 1'b1, s2: 1'b1, level: 1'b1, cnt: '0};
    end else begin
      s <= next_s;
    end
  end

  assign o_level = s.level;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  property p_filt_stable;
    $changed(s.level) |-> $past(s.cnt) == STABLE_CYCLES - wsm_pkg::FILT_ONE;
  endproperty
  a_filt_stable: assert property (p_filt_stable) else $error("filter level moved before input was stable");
endmodule
`default_nettype wire

// ---- verilog/wsm_pkg.sv ----
// Shared constants, state types and register layout for the watchdog and supply monitor
package wsm_pkg;
  // Register addresses and power-on values
  localparam logic [7:0] WSM_SMC_ADDR = 8'hDF;
  localparam logic [7:0] WSM_SMC_RESET = 8'hDE;
  localparam logic [7:0] WSM_WDC_ADDR = 8'hC0;
  localparam logic [7:0] WSM_WDC_RESET = 8'h00;
  // Watchdog control field positions
  localparam int WDC_UNLOCK = 0;
  localparam int WDC_ENABLE = 1;
  localparam int WDC_STATUS = 2;
  localparam int WDC_RESP = 3;
  localparam int WDC_PRE_LO = 4;
  localparam int WDC_PRE_HI = 7;
  // Supply monitor control field positions
  localparam int SMC_ON = 0;
  localparam int SMC_TPA_LO = 1;
  localparam int SMC_TPA_HI = 2;
  localparam int SMC_TPD_LO = 3;
  localparam int SMC_TPD_HI = 4;
  localparam int SMC_FLAG = 5;
  localparam int SMC_ANALOG_SUPPLY_COMPARATOR = 6;
  localparam int SMC_DIGITAL_SUPPLY_COMPARATOR = 7;
  // Timing figures in their own units
  localparam int CLK_HZ = 10_000_000;
  localparam int WDOG_TIMEOUT_MS = 2000;
  localparam int RECOVER_MS = 250;
  localparam int FILTER_US = 50;
  localparam int CNT_W = 32;
  localparam int FILT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
  localparam logic [FILT_W-1:0] FILT_ONE = 16'h0001;
  // Unlock sequence states, Gray coded
  typedef enum logic [1:0] {
    WSM_UL_IDLE = 2'b00,
    WSM_UL_PEND = 2'b01,
    WSM_UL_OPEN = 2'b11
  } wsm_ul_t;
  // Main block state
  typedef struct packed {
    logic [3:0] prescale;
    logic resp_sel;
    logic status;
    logic enable;
    wsm_ul_t ul;
    logic [CNT_W-1:0] wdog_cnt;
    logic flag;
    logic [CNT_W-1:0] rec_cnt;
    logic [1:0] trip_a;
    logic [1:0] trip_d;
    logic mon_on;
    logic irq_q;
    logic wdog_irq;
    logic wdog_rst;
    logic [7:0] rdata;
  } wsm_state_t;
  // Comparator filter state
  typedef struct packed {
    logic s1;
    logic s2;
    logic level;
    logic [FILT_W-1:0] cnt;
  } wsm_filt_t;
endpackage

// ---- verilog/wsm_top.sv ----
// Watchdog control register end and supply monitor with latched alarm
// What this block does
// - Writing one to the watchdog enable bit turns the watchdog on and zeroes its counter.
// - If enable is not rewritten with one before the timeout, a reset or an interrupt follows per the response select.
// - The enable bit clears on a written zero, a reset-response timeout, hardware reset and a supply interrupt.
// - Software sets the write unlock and writes the control register with the very next instruction.
// - When on, the monitor watches both supplies against trip levels chosen from four settings each.
// - The alarm reaches the core as an interrupt only when the secondary interrupt enable allows it.
// - The alarm flag stays set until the supply has been good for 250 ms without a break, or until software clears it while the supply is good.
// - Short glitches on the comparator outputs are filtered out.
// - The supply monitor control register sits at DFH, resets to DEH and is byte access only.
// - With response select one, a timeout raises a fixed non-maskable interrupt instead of a reset.
// - Either comparator low sets the flag, and the 250 ms count starts once both are high again.
// - Software may write the flag but a clear is ignored while either comparator is low.
// - Bit 0 of the supply monitor control register turns the monitor circuit on and off.
`timescale 1ns/1ps
`default_nettype none
module wsm_top #(
  parameter logic [wsm_pkg::CNT_W-1:0] WDOG_CYCLES = 32'(wsm_pkg::WDOG_TIMEOUT_MS * (wsm_pkg::CLK_HZ / 1000)),
  parameter logic [wsm_pkg::CNT_W-1:0] RECOVER_CYCLES = 32'(wsm_pkg::RECOVER_MS * (wsm_pkg::CLK_HZ / 1000)),
  parameter logic [wsm_pkg::FILT_W-1:0] FILT_CYCLES = 16'(wsm_pkg::FILTER_US * (wsm_pkg::CLK_HZ / 1_000_000))
) (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_instr_end,
  input wire logic i_supply_irq_en,
  input wire logic i_analog_supply_comparator,
  input wire logic i_digital_supply_comparator,
  output logic o_supply_monitor_on,
  output logic [1:0] o_trip_sel_a,
  output logic [1:0] o_trip_sel_d,
  output logic o_supply_irq,
  output logic o_wdog_enable_bit,
  output logic o_wdog_irq,
  output logic o_wdog_rst
);
  wsm_pkg::wsm_state_t s;
  wsm_pkg::wsm_state_t next_s;
  logic cmp_a;
  logic cmp_d;
  logic wr_wdc;
  logic wr_smc;
  logic supply_low;
  logic supply_irq;
  logic wd_timeout;
  logic [7:0] wdc_view;
  logic [7:0] smc_view;

  // Filtered comparator levels, one per supply
  wsm_filt #(.STABLE_CYCLES(FILT_CYCLES)) u_filt_a (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_cmp_async(i_analog_supply_comparator),
    .o_level(cmp_a)
  );
  wsm_filt #(.STABLE_CYCLES(FILT_CYCLES)) u_filt_d (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_cmp_async(i_digital_supply_comparator),
    .o_level(cmp_d)
  );

  // Decodes, alarm condition and register views
  assign wr_wdc = i_sfr_wr && (i_sfr_addr == wsm_pkg::WSM_WDC_ADDR);
  assign wr_smc = i_sfr_wr && (i_sfr_addr == wsm_pkg::WSM_SMC_ADDR);
  assign supply_low = s.mon_on && (!cmp_a || !cmp_d);
  assign supply_irq = s.flag && i_supply_irq_en;
  // Timeout condition, shared by the status clear and the irq gate assertion
  assign wd_timeout = s.enable && (s.wdog_cnt == WDOG_CYCLES - wsm_pkg::CNT_ONE);
  assign wdc_view = {s.prescale, s.resp_sel, s.status, s.enable, s.ul == wsm_pkg::WSM_UL_OPEN};
  assign smc_view = {cmp_d, cmp_a, s.flag, s.trip_d, s.trip_a, s.mon_on};

  // Next-state logic for the whole block
  always_comb begin
    next_s = s;
    next_s.wdog_irq = 1'b0;
    next_s.wdog_rst = 1'b0;
    next_s.irq_q = supply_irq;
    case (s.ul)
      wsm_pkg::WSM_UL_IDLE: next_s.ul = wsm_pkg::WSM_UL_IDLE;
      wsm_pkg::WSM_UL_PEND: begin
        if (i_instr_end) begin
          next_s.ul = wsm_pkg::WSM_UL_OPEN;
        end
      end
      wsm_pkg::WSM_UL_OPEN: begin
        if (i_instr_end) begin
          next_s.ul = wsm_pkg::WSM_UL_IDLE;
        end
      end
      default: next_s.ul = wsm_pkg::WSM_UL_IDLE;
    endcase
    // Watchdog counter and timeout response
    if (s.enable) begin
      if (s.wdog_cnt == WDOG_CYCLES - wsm_pkg::CNT_ONE) begin
        next_s.wdog_cnt = '0;
        next_s.status = 1'b1;
        if (s.resp_sel) begin
          next_s.wdog_irq = 1'b1;
        end else begin
          next_s.wdog_rst = 1'b1;
          next_s.enable = 1'b0;
        end
      end else begin
        next_s.wdog_cnt = s.wdog_cnt + wsm_pkg::CNT_ONE;
      end
    end
    if (wr_wdc) begin
      if (s.ul == wsm_pkg::WSM_UL_OPEN) begin
        next_s.prescale = i_sfr_wdata[wsm_pkg::WDC_PRE_HI:wsm_pkg::WDC_PRE_LO];
        next_s.resp_sel = i_sfr_wdata[wsm_pkg::WDC_RESP];
        next_s.enable = i_sfr_wdata[wsm_pkg::WDC_ENABLE];
        // A timeout in the same cycle keeps status set
        if (!i_sfr_wdata[wsm_pkg::WDC_STATUS] && !wd_timeout) begin
          next_s.status = 1'b0;
        end
        if (i_sfr_wdata[wsm_pkg::WDC_ENABLE]) begin
          next_s.wdog_cnt = '0;
        end
        next_s.ul = wsm_pkg::WSM_UL_IDLE;
      end else if (i_sfr_wdata[wsm_pkg::WDC_UNLOCK]) begin
        next_s.ul = i_instr_end ? wsm_pkg::WSM_UL_OPEN : wsm_pkg::WSM_UL_PEND;
      end
    end
    if (supply_irq && !s.irq_q) begin
      next_s.enable = 1'b0;
    end
    // Supply monitor control writes
    if (wr_smc) begin
      next_s.mon_on = i_sfr_wdata[wsm_pkg::SMC_ON];
      next_s.trip_a = i_sfr_wdata[wsm_pkg::SMC_TPA_HI:wsm_pkg::SMC_TPA_LO];
      next_s.trip_d = i_sfr_wdata[wsm_pkg::SMC_TPD_HI:wsm_pkg::SMC_TPD_LO];
      if (i_sfr_wdata[wsm_pkg::SMC_FLAG]) begin
        next_s.flag = 1'b1;
        next_s.rec_cnt = '0;
      end else if (!supply_low) begin
        next_s.flag = 1'b0;
      end
    end
    // set on low, recover after good run
    if (supply_low) begin
      next_s.flag = 1'b1;
      next_s.rec_cnt = '0;
    end else if (s.flag && next_s.flag && !(wr_smc && i_sfr_wdata[wsm_pkg::SMC_FLAG])) begin
      // A software set in the same cycle wins and restarts the count
      // unbroken 250 ms recovery
      if (s.rec_cnt == RECOVER_CYCLES - wsm_pkg::CNT_ONE) begin
        next_s.flag = 1'b0;
        next_s.rec_cnt = '0;
      end else begin
        next_s.rec_cnt = s.rec_cnt + wsm_pkg::CNT_ONE;
      end
    end
    if (i_sfr_rd) begin
      if (i_sfr_addr == wsm_pkg::WSM_SMC_ADDR) begin
        next_s.rdata = smc_view;
      end else if (i_sfr_addr == wsm_pkg::WSM_WDC_ADDR) begin
        next_s.rdata = wdc_view;
      end else begin
        next_s.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s <= '{prescale: wsm_pkg::WSM_WDC_RESET[wsm_pkg::WDC_PRE_HI:wsm_pkg::WDC_PRE_LO],
             resp_sel: wsm_pkg::WSM_WDC_RESET[wsm_pkg::WDC_RESP],
             status: wsm_pkg::WSM_WDC_RESET[wsm_pkg::WDC_STATUS],
             enable: wsm_pkg::WSM_WDC_RESET[wsm_pkg::WDC_ENABLE],
             ul: wsm_pkg::WSM_UL_IDLE,
             wdog_cnt: '0,
             flag: wsm_pkg::WSM_SMC_RESET[wsm_pkg::SMC_FLAG],
             rec_cnt: '0,
             trip_a: wsm_pkg::WSM_SMC_RESET[wsm_pkg::SMC_TPA_HI:wsm_pkg::SMC_TPA_LO],
             trip_d: wsm_pkg::WSM_SMC_RESET[wsm_pkg::SMC_TPD_HI:wsm_pkg::SMC_TPD_LO],
             mon_on: wsm_pkg::WSM_SMC_RESET[wsm_pkg::SMC_ON],
             irq_q: 1'b0,
             wdog_irq: 1'b0,
             wdog_rst: 1'b0,
             rdata: 8'h00};
    end else begin
      s <= next_s;
    end
  end

  // Outputs
  assign o_sfr_rdata = s.rdata;
  assign o_supply_monitor_on = s.mon_on;
  assign o_trip_sel_a = s.trip_a;
  assign o_trip_sel_d = s.trip_d;
  assign o_supply_irq = supply_irq;
  assign o_wdog_enable_bit = s.enable;
  assign o_wdog_irq = s.wdog_irq;
  assign o_wdog_rst = s.wdog_rst;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  property p_enable_restart;
    wr_wdc && s.ul == wsm_pkg::WSM_UL_OPEN && i_sfr_wdata[wsm_pkg::WDC_ENABLE] && !(supply_irq && !s.irq_q)
      |=> s.enable && s.wdog_cnt == '0;
  endproperty
  a_enable_restart: assert property (p_enable_restart) else $error("enable write did not restart watchdog");
  property p_timeout_reset;
    s.enable && !s.resp_sel && s.wdog_cnt == WDOG_CYCLES - wsm_pkg::CNT_ONE && !wr_wdc |=> o_wdog_rst && !o_wdog_irq;
  endproperty
  a_timeout_reset: assert property (p_timeout_reset) else $error("timeout without reset");
  property p_timeout_irq;
    s.enable && s.resp_sel && s.wdog_cnt == WDOG_CYCLES - wsm_pkg::CNT_ONE |=> o_wdog_irq && !o_wdog_rst;
  endproperty
  a_timeout_irq: assert property (p_timeout_irq) else $error("interrupt response missing");
  property p_rst_clears;
    o_wdog_rst |-> !s.enable ##1 !o_wdog_rst;
  endproperty
  a_rst_clears: assert property (p_rst_clears) else $error("enable survived reset response");
  property p_locked_write;
    wr_wdc && s.ul != wsm_pkg::WSM_UL_OPEN |=> s.prescale == $past(s.prescale) && s.resp_sel == $past(s.resp_sel);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("locked control write took effect");
  property p_low_sets;
    supply_low |=> s.flag && s.rec_cnt == '0;
  endproperty
  a_low_sets: assert property (p_low_sets) else $error("low supply did not set flag");
  property p_clear_refused;
    wr_smc && !i_sfr_wdata[wsm_pkg::SMC_FLAG] && supply_low |=> s.flag;
  endproperty
  a_clear_refused: assert property (p_clear_refused) else $error("flag cleared while supply low");
  property p_recover_time;
    $fell(s.flag) && !$past(wr_smc) |-> $past(s.rec_cnt) == RECOVER_CYCLES - wsm_pkg::CNT_ONE;
  endproperty
  a_recover_time: assert property (p_recover_time) else $error("flag cleared before recovery time");
  property p_irq_gate;
    !i_supply_irq_en && s.enable && !wr_wdc && !wd_timeout |=> s.enable;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("masked supply alarm acted on watchdog");
  property p_off_quiet;
    !s.mon_on && !s.flag && !wr_smc |=> !s.flag;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("monitor off but alarm flag set");
  property p_smc_read;
    i_sfr_rd && i_sfr_addr == wsm_pkg::WSM_SMC_ADDR |=> o_sfr_rdata[wsm_pkg::SMC_FLAG] == $past(s.flag);
  endproperty
  a_smc_read: assert property (p_smc_read) else $error("supply register read wrong");

  c_wdog_rst: cover property (o_wdog_rst);
  c_wdog_irq: cover property (o_wdog_irq);
  c_flag_recover: cover property ($fell(s.flag));
  c_unlock_write: cover property (wr_wdc && s.ul == wsm_pkg::WSM_UL_OPEN);
endmodule
`default_nettype wire
